// ### include/fpcp_cfg.svh
// constants for the flash pin control and protection block
`ifndef FPCP_CFG_SVH
`define FPCP_CFG_SVH
`define FPCP_GPI_W 5
`define FPCP_STRAP_W 4
`define FPCP_NIB_W 4
`define FPCP_BOOT_ID 4'h0
`define FPCP_GPI_AAI_LO 2
`define FPCP_GPI_RST 5'h00
`define FPCP_NIB_RST 4'h0
`define FPCP_BYTE_RST 8'h00
`define FPCP_PIN_SAMPLE_RST 1'b0
`define FPCP_PROG_CYCLES 16
`endif

// ### include/fpcp_pkg.sv
// types for the flash pin control and protection block
package fpcp_pkg;
  typedef enum logic [1:0]
  {
    FPCP_IDLE = 2'h0,
    FPCP_PROG = 2'h1,
    FPCP_DONE = 2'h3
  } fpcp_eng_type;
  typedef enum logic
  {
    FPCP_MODE_LPC = 1'h0,
    FPCP_MODE_AAI = 1'h1
  } fpcp_mode_type;
endpackage

// ### include/fpcp_ctl_if.sv
// control carrier between the top, protection and programming modules
`timescale 1ns/1ps
`default_nettype none
interface fpcp_ctl_if;
  logic aai_mode;
  logic op_start;
  logic op_top;
  logic top_lock_bit;
  logic blk_lock_bit;
  logic op_allowed;
  modport top (output aai_mode, output op_top, output top_lock_bit, output blk_lock_bit,
    input op_start, input op_allowed);
  modport prot (input aai_mode, input op_start, input op_top, input top_lock_bit,
    input blk_lock_bit, output op_allowed);
  modport aai (input aai_mode, input op_allowed, output op_start);
endinterface
`default_nettype wire

// ### rtl/fpcp_protect.sv
// hardware write protection evaluated from pins sampled at operation start
`timescale 1ns/1ps
`default_nettype none
`include "fpcp_cfg.svh"
module fpcp_protect
  import fpcp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_i_n,
  input wire logic clk_en,
  input wire logic top_block_lock_n,
  input wire logic wp_level,
  fpcp_ctl_if.prot ctl
);
  logic tbl_q;
  logic tbl_d;
  logic wp_q;
  logic wp_d;
  logic tbl_eff;
  logic wp_eff;

  always_comb
  begin
    tbl_d = tbl_q;
    wp_d = wp_q;
    if (ctl.op_start)
    begin
      tbl_d = top_block_lock_n;
      wp_d = wp_level;
    end
    tbl_eff = ctl.op_start ? top_block_lock_n : tbl_q;
    wp_eff = ctl.op_start ? wp_level : wp_q;
    // a low pin protects whatever the lock register shows; mode overrides both the top pin and the write protect pin
    if (ctl.op_top)
      ctl.op_allowed = (ctl.aai_mode | tbl_eff) & ~ctl.top_lock_bit;
    else
      ctl.op_allowed = (ctl.aai_mode | wp_eff) & ~ctl.blk_lock_bit;
  end

  always_ff @(posedge clock or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      tbl_q <= `FPCP_PIN_SAMPLE_RST;
      wp_q <= `FPCP_PIN_SAMPLE_RST;
    end
    else if (clk_en)
    begin
      tbl_q <= tbl_d;
      wp_q <= wp_d;
    end
  end

  AST_TBL_LOCK: assert property (@(posedge clock) disable iff (!rst_i_n)
    ctl.op_start && ctl.op_top && !ctl.aai_mode && !top_block_lock_n |-> !ctl.op_allowed)
    else $error("top block not protected by low lock pin");
  AST_AAI_TBL: assert property (@(posedge clock) disable iff (!rst_i_n)
    ctl.op_start && ctl.op_top && ctl.aai_mode && !ctl.top_lock_bit |-> ctl.op_allowed)
    else $error("top lock pin not ignored in auto-increment mode");
  AST_WP_LOCK: assert property (@(posedge clock) disable iff (!rst_i_n)
    ctl.op_start && !ctl.op_top && !ctl.aai_mode |-> ctl.op_allowed == (wp_level && !ctl.blk_lock_bit))
    else $error("main block protection wrong");
  AST_HOLD: assert property (@(posedge clock) disable iff (!rst_i_n)
    clk_en && ctl.op_start ##1 !ctl.op_start [*2] |-> tbl_q == $past(top_block_lock_n, 2))
    else $error("protection sample not held");
endmodule
`default_nettype wire

// ### rtl/fpcp_aai.sv
// auto-increment load capture, program engine and ready/busy pin
`timescale 1ns/1ps
`default_nettype none
`include "fpcp_cfg.svh"
module fpcp_aai
  import fpcp_pkg::*;
#(
  parameter int PROG_CYCLES = `FPCP_PROG_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_i_n,
  input wire logic clk_en,
  fpcp_ctl_if.aai ctl,
  input wire logic load_strobe_n,
  input wire logic [`FPCP_NIB_W-1:0] load_nibble,
  input wire logic lpc_op_start,
  output logic ready_busy_flag_out_o,
  output logic ready_busy_flag_out_oe,
  output logic busy,
  output logic prog_done,
  output logic op_refused,
  output logic [7:0] prog_data
);
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam int PL = PROG_CYCLES;
  generate
    if (PROG_CYCLES < 1)
      $error("PROG_CYCLES must be at least 1");
  endgenerate

  fpcp_eng_type eng_q;
  fpcp_eng_type eng_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [`FPCP_NIB_W-1:0] low_q;
  logic [`FPCP_NIB_W-1:0] low_d;
  logic have_low_q;
  logic have_low_d;
  logic [7:0] buf_q;
  logic [7:0] buf_d;
  logic buf_full_q;
  logic buf_full_d;
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic capture;
  logic ready;

  // a full buffer refuses further nibbles rather than overwrite a byte
  assign capture = ctl.aai_mode && !load_strobe_n && !buf_full_q;
  assign ctl.op_start = (eng_q == FPCP_IDLE) &&
    (ctl.aai_mode ? buf_full_q : lpc_op_start);

  always_comb
  begin
    eng_d = eng_q;
    cnt_d = cnt_q;
    low_d = low_q;
    have_low_d = have_low_q;
    buf_d = buf_q;
    buf_full_d = buf_full_q;
    data_d = data_q;
    if (ctl.op_start && ctl.aai_mode)
      buf_full_d = 1'b0;
    if (capture)
    begin
      if (!have_low_q)
      begin
        low_d = load_nibble;
        have_low_d = 1'b1;
      end
      else
      begin
        buf_d = {load_nibble, low_q};
        buf_full_d = 1'b1;
        have_low_d = 1'b0;
      end
    end
    else if (load_strobe_n || !ctl.aai_mode)
      have_low_d = 1'b0;
    case (eng_q)
      FPCP_IDLE:
      begin
        if (ctl.op_start && ctl.op_allowed)
        begin
          eng_d = FPCP_PROG;
          cnt_d = CW'(PROG_CYCLES - 1);
          data_d = buf_q;
        end
      end
      FPCP_PROG:
      begin
        if (cnt_q == '0)
          eng_d = FPCP_DONE;
        else
          cnt_d = cnt_q - CW'(1);
      end
      FPCP_DONE:
        eng_d = FPCP_IDLE;
      default:
        eng_d = FPCP_IDLE;
    endcase
  end

  // reset clears the engine mid-operation: the byte being written is abandoned
  always_ff @(posedge clock or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      eng_q <= FPCP_IDLE;
      cnt_q <= '0;
      low_q <= `FPCP_NIB_RST;
      have_low_q <= 1'b0;
      buf_q <= `FPCP_BYTE_RST;
      buf_full_q <= 1'b0;
      data_q <= `FPCP_BYTE_RST;
    end
    else if (clk_en)
    begin
      eng_q <= eng_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      have_low_q <= have_low_d;
      buf_q <= buf_d;
      buf_full_q <= buf_full_d;
      data_q <= data_d;
    end
  end

  // strobe low reports buffer free, strobe high reports programming complete
  assign ready = !load_strobe_n ? !buf_full_q : (eng_q == FPCP_IDLE) && !buf_full_q;
  assign ready_busy_flag_out_o = 1'b0;
  assign ready_busy_flag_out_oe = ctl.aai_mode && !ready;
  assign busy = (eng_q != FPCP_IDLE);
  assign prog_done = (eng_q == FPCP_DONE);
  assign op_refused = ctl.op_start && !ctl.op_allowed;
  assign prog_data = data_q;

  AST_LOAD_PAIR: assert property (@(posedge clock) disable iff (!rst_i_n)
    clk_en && capture && have_low_q |=> buf_full_q && buf_q == {$past(load_nibble), $past(low_q)})
    else $error("loaded byte not assembled on clock edge");
  AST_RB_BUF: assert property (@(posedge clock) disable iff (!rst_i_n)
    ctl.aai_mode && !load_strobe_n && buf_full_q |-> ready_busy_flag_out_oe)
    else $error("busy not shown while buffer full");
  AST_RB_DONE: assert property (@(posedge clock) disable iff (!rst_i_n)
    ctl.aai_mode && load_strobe_n && eng_q == FPCP_PROG |-> ready_busy_flag_out_oe)
    else $error("ready shown while programming");
  AST_PROG_LEN: assert property (@(posedge clock) disable iff (!rst_i_n || !clk_en)
    $rose(busy) |-> ##[1:PL] prog_done)
    else $error("program cycle did not finish in time");
endmodule
`default_nettype wire

// ### rtl/fpcp_top.sv
// pin control: reset merge, id straps, general inputs, protection and mode select
`timescale 1ns/1ps
`default_nettype none
`include "fpcp_cfg.svh"
// Overview of operation
// - either reset pin low resets the device
// - straps give identity, zero means boot device
// - straps act the same in auto-increment mode
// - general input levels readable over the bus
// - general inputs two to four ignored in auto-increment
// - low top lock pin blocks boot block programming
// - top lock pin ignored in auto-increment mode
// - low write protect blocks all other blocks outside auto-increment mode
// - supervoltage on mode pin selects auto-increment
// - open-drain ready/busy driven in auto-increment mode
// - load level picks buffer-free or complete flag
// - reset during read deselects and floats bus data
// - reset aborts a running program
// - top lock pin ORed with boot lock bit
// - loaded data captured on rising clock edge
module fpcp_top
  import fpcp_pkg::*;
#(
  parameter int PROG_CYCLES = `FPCP_PROG_CYCLES,
  parameter int GPI_W = `FPCP_GPI_W,
  parameter int STRAP_W = `FPCP_STRAP_W
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic init_n,
  input wire logic [STRAP_W-1:0] chip_select_straps,
  input wire logic [STRAP_W-1:0] cycle_id,
  input wire logic cycle_id_valid,
  output logic id_match,
  output logic boot_device,
  input wire logic [GPI_W-1:0] general_input_pins,
  input wire logic gpi_rd_start,
  output logic [GPI_W-1:0] gpi_rd_data,
  input wire logic top_block_lock_n,
  input wire logic write_protect_mode_pin,
  input wire logic mode_pin_supervoltage,
  output logic auto_increment_program_mode,
  input wire logic boot_lock_bit,
  input wire logic block_lock_bit,
  input wire logic lpc_op_start,
  input wire logic op_top_block,
  output logic op_allowed,
  output logic op_refused,
  output logic busy,
  output logic prog_done,
  output logic [7:0] prog_data,
  input wire logic load_strobe_n,
  input wire logic [`FPCP_NIB_W-1:0] lad_in,
  input wire logic lad_drive_req,
  input wire logic [`FPCP_NIB_W-1:0] lad_drive_data,
  output logic [`FPCP_NIB_W-1:0] lad_out,
  output logic lad_oe,
  output logic ready_busy_flag_out_o,
  output logic ready_busy_flag_out_oe,
  output logic device_reset_n
);
  generate
    if (GPI_W != `FPCP_GPI_W || STRAP_W != `FPCP_STRAP_W)
      $error("general input and strap widths are fixed by the pinout");
  endgenerate

  fpcp_ctl_if ctl ();

  logic rst_any_n;
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_i_n;

  // both reset pins feed one asynchronous reset; release is synchronised
  assign rst_any_n = rst_n & init_n;

  always_ff @(posedge clock or negedge rst_any_n)
  begin
    if (!rst_any_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign rst_i_n = rst_s2_q;
  assign device_reset_n = rst_i_n;

  fpcp_mode_type mode_q;
  fpcp_mode_type mode_d;
  logic [STRAP_W-1:0] strap_q;
  logic [STRAP_W-1:0] strap_d;
  logic id_match_q;
  logic id_match_d;
  logic [GPI_W-1:0] gpi_q;
  logic [GPI_W-1:0] gpi_d;
  logic [GPI_W-1:0] gpi_keep;
  logic [`FPCP_NIB_W-1:0] lad_q;
  logic [`FPCP_NIB_W-1:0] lad_d;
  logic lad_oe_q;
  logic lad_oe_d;

  // per-bit mask: upper general inputs are don't-care in auto-increment mode
  genvar gi;
  generate
    for (gi = 0; gi < GPI_W; gi++)
    begin : g_gpi
      if (gi >= `FPCP_GPI_AAI_LO)
        assign gpi_keep[gi] = (mode_q == FPCP_MODE_LPC);
      else
        assign gpi_keep[gi] = 1'b1;
    end
  endgenerate

  always_comb
  begin
    // mode follows the supervoltage detector on the write protect pin
    mode_d = mode_pin_supervoltage ? FPCP_MODE_AAI : FPCP_MODE_LPC;
    // straps are re-sampled every cycle, identically in both modes
    strap_d = chip_select_straps;
    id_match_d = id_match_q;
    if (cycle_id_valid)
      id_match_d = (cycle_id == strap_q);
    gpi_d = gpi_q;
    // the host guarantees stable inputs from before the read cycle to its end
    if (gpi_rd_start)
      gpi_d = general_input_pins & gpi_keep;
    lad_d = lad_q;
    lad_oe_d = lad_drive_req;
    if (lad_drive_req)
      lad_d = lad_drive_data;
  end

  always_ff @(posedge clock or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      mode_q <= FPCP_MODE_LPC;
      strap_q <= `FPCP_BOOT_ID;
      id_match_q <= 1'b0;
      gpi_q <= `FPCP_GPI_RST;
      lad_q <= `FPCP_NIB_RST;
      lad_oe_q <= 1'b0;
    end
    else if (clk_en)
    begin
      mode_q <= mode_d;
      strap_q <= strap_d;
      id_match_q <= id_match_d;
      gpi_q <= gpi_d;
      lad_q <= lad_d;
      lad_oe_q <= lad_oe_d;
    end
  end

  // the raw pin drops the drivers at once; the synchronised copy keeps them off
  assign lad_oe = lad_oe_q && rst_any_n;
  assign lad_out = lad_q;
  assign id_match = id_match_q && rst_i_n;
  assign boot_device = (strap_q == `FPCP_BOOT_ID);
  assign gpi_rd_data = gpi_q;
  assign auto_increment_program_mode = (mode_q == FPCP_MODE_AAI);

  assign ctl.aai_mode = (mode_q == FPCP_MODE_AAI);
  assign ctl.op_top = op_top_block;
  assign ctl.top_lock_bit = boot_lock_bit;
  assign ctl.blk_lock_bit = block_lock_bit;
  assign op_allowed = ctl.op_allowed;

  // in auto-increment mode the pin carries supervoltage, so it is not a protect level
  fpcp_protect u_protect (
    .clock(clock),
    .rst_i_n(rst_i_n),
    .clk_en(clk_en),
    .top_block_lock_n(top_block_lock_n),
    .wp_level(write_protect_mode_pin),
    .ctl(ctl.prot)
  );

  fpcp_aai #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_aai (
    .clock(clock),
    .rst_i_n(rst_i_n),
    .clk_en(clk_en),
    .ctl(ctl.aai),
    .load_strobe_n(load_strobe_n),
    .load_nibble(lad_in),
    .lpc_op_start(lpc_op_start),
    .ready_busy_flag_out_o(ready_busy_flag_out_o),
    .ready_busy_flag_out_oe(ready_busy_flag_out_oe),
    .busy(busy),
    .prog_done(prog_done),
    .op_refused(op_refused),
    .prog_data(prog_data)
  );

  AST_RST_MERGE: assert property (@(posedge clock) disable iff (!rst_n)
    !init_n |-> ##[0:2] !rst_i_n)
    else $error("secondary reset pin did not reset the device");
  AST_RST_FLOAT: assert property (@(posedge clock)
    !rst_i_n |-> !lad_oe && !id_match)
    else $error("bus data driven during reset");
  // the engine is cleared asynchronously, so busy must already be low while reset is held
  AST_RST_ABORT: assert property (@(posedge clock)
    (!init_n || !rst_n) |-> !busy)
    else $error("reset did not abort program");
  AST_ID_MATCH: assert property (@(posedge clock) disable iff (!rst_i_n)
    clk_en && cycle_id_valid ##1 clk_en |-> ##1
      id_match == ($past(cycle_id, 2) == $past(chip_select_straps, 3)))
    else $error("strap match wrong");
  AST_GPI_READ: assert property (@(posedge clock) disable iff (!rst_i_n)
    clk_en && gpi_rd_start && mode_q == FPCP_MODE_LPC |=> gpi_rd_data == $past(general_input_pins))
    else $error("general input value not captured");
  AST_GPI_AAI: assert property (@(posedge clock) disable iff (!rst_i_n)
    clk_en && gpi_rd_start && mode_q == FPCP_MODE_AAI |=> gpi_rd_data[GPI_W-1:2] == '0)
    else $error("upper general inputs not ignored");
  AST_MODE: assert property (@(posedge clock) disable iff (!rst_i_n)
    clk_en && mode_pin_supervoltage && $past(rst_i_n) ##1 clk_en && mode_pin_supervoltage
      |-> auto_increment_program_mode)
    else $error("supervoltage did not select auto-increment mode");
  AST_BOOT_OR: assert property (@(posedge clock) disable iff (!rst_i_n)
    ctl.op_start && op_top_block && top_block_lock_n && boot_lock_bit |-> !op_allowed)
    else $error("boot lock bit not honoured");
endmodule
`default_nettype wire

// ### verif/fpcp_host_model.sv
// host-side model: drives auto-increment loads and resolves the ready/busy line
`timescale 1ns/1ps
`default_nettype none
module fpcp_host_model
(
  input wire logic clock,
  input wire logic go,
  input wire logic [7:0] byte_in,
  input wire logic rb_oe,
  output logic load_strobe_n,
  output logic [3:0] lad_in,
  output logic rb_level
);
  logic [1:0] step_q = 2'h0;
  // open-drain line with a pull-up: high unless the device pulls it
  assign rb_level = rb_oe ? 1'b0 : 1'b1;
  initial load_strobe_n = 1'b1;
  initial lad_in = 4'hA;
  always @(posedge clock)
  begin
    if (go && step_q == 2'h0)
    begin
      load_strobe_n <= 1'b0;
      lad_in <= byte_in[3:0];
      step_q <= 2'h1;
    end
    else if (step_q == 2'h1)
    begin
      lad_in <= byte_in[7:4];
      step_q <= 2'h2;
    end
    else
    begin
      // end the command at once; a released bus must not keep the last nibble
      load_strobe_n <= 1'b1;
      lad_in <= ~lad_in;
      step_q <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// ### verif/fpcp_top_tb.sv
// self-checking bench for the flash pin control and protection block
`timescale 1ns/1ps
`default_nettype none
module fpcp_top_tb;
  import fpcp_pkg::*;
  localparam int PROG_N = 2;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic init_n = 1'b1;
  logic [3:0] straps = 4'h0;
  logic [3:0] cyc_id = 4'h0;
  logic cyc_vld = 1'b0;
  logic [4:0] gpi = 5'h00;
  logic gpi_rd = 1'b0;
  logic gpi_pend = 1'b0;
  logic tbl_n = 1'b1;
  logic wp_pin = 1'b1;
  logic sv = 1'b0;
  logic boot_lk = 1'b0;
  logic blk_lk = 1'b0;
  logic op_go = 1'b0;
  logic op_top = 1'b0;
  logic drv_req = 1'b0;
  logic [3:0] drv_data = 4'h0;
  logic host_go = 1'b0;
  logic [7:0] host_byte = 8'h00;
  logic id_match, boot_device, mode, op_allowed, op_refused, busy, prog_done;
  logic lad_oe, rb_o, rb_oe, dev_rst_n, ld_n, rb_level;
  logic [4:0] gpi_rd_data;
  logic [7:0] prog_data;
  logic [3:0] lad_out, lad_in;
  logic [9:0] note_q[$];
  logic [31:0] rng = 32'h000178CB;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  fpcp_top #(.PROG_CYCLES(PROG_N)) fpcp_top_i (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .init_n(init_n), .chip_select_straps(straps), .cycle_id(cyc_id), .cycle_id_valid(cyc_vld),
    .id_match(id_match), .boot_device(boot_device), .general_input_pins(gpi),
    .gpi_rd_start(gpi_rd), .gpi_rd_data(gpi_rd_data), .top_block_lock_n(tbl_n),
    .write_protect_mode_pin(wp_pin), .mode_pin_supervoltage(sv),
    .auto_increment_program_mode(mode), .boot_lock_bit(boot_lk), .block_lock_bit(blk_lk),
    .lpc_op_start(op_go), .op_top_block(op_top), .op_allowed(op_allowed),
    .op_refused(op_refused), .busy(busy), .prog_done(prog_done), .prog_data(prog_data),
    .load_strobe_n(ld_n), .lad_in(lad_in), .lad_drive_req(drv_req),
    .lad_drive_data(drv_data), .lad_out(lad_out), .lad_oe(lad_oe),
    .ready_busy_flag_out_o(rb_o), .ready_busy_flag_out_oe(rb_oe),
    .device_reset_n(dev_rst_n));
  fpcp_host_model fpcp_host_model_i (.clock(clock), .go(host_go), .byte_in(host_byte),
    .rb_oe(rb_oe), .load_strobe_n(ld_n), .lad_in(lad_in), .rb_level(rb_level));
  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
  endtask
  task automatic wait_idle();
    @(posedge clock);
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
      @(posedge clock);
  endtask
  task automatic bus_op(input logic top, input logic pin, input logic lk);
    @(posedge clock);
    op_top <= top;
    tbl_n <= top ? pin : ~pin;
    wp_pin <= top ? ~pin : pin;
    boot_lk <= top ? lk : ~lk;
    blk_lk <= top ? ~lk : lk;
    op_go <= 1'b1;
    note_q.push_back((pin & ~lk) ? 10'h100 : 10'h000);
    @(posedge clock);
    op_go <= 1'b0;
    // pins dropped mid-operation must not change its outcome
    tbl_n <= 1'b0;
    wp_pin <= 1'b0;
    wait_idle();
  endtask
  task automatic aai_load(input logic [7:0] b, input bit abort);
    @(posedge clock);
    host_byte <= b;
    host_go <= 1'b1;
    note_q.push_back({2'h2, b});
    @(posedge clock);
    host_go <= 1'b0;
    repeat (4) @(posedge clock);
    if (abort)
    begin
      rst_n <= 1'b0;
      #1;
      cmp("busy after reset", 10'h000, {9'h000, busy});
      void'(note_q.pop_back());
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
    end
    wait_idle();
  endtask
  task automatic gpi_read();
    nxt();
    @(posedge clock);
    gpi <= rng[4:0];
    @(posedge clock);
    gpi_rd <= 1'b1;
    note_q.push_back({5'h18, (mode === 1'b1) ? (gpi & 5'h03) : gpi});
    @(posedge clock);
    gpi_rd <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic id_chk(input int k);
    logic [3:0] s;
    nxt();
    s = (k == 0) ? 4'h0 : rng[3:0];
    @(posedge clock);
    straps <= s;
    @(posedge clock);
    cyc_id <= k[0] ? s ^ 4'h1 : s;
    cyc_vld <= 1'b1;
    @(posedge clock);
    cyc_vld <= 1'b0;
    @(posedge clock);
    cmp("id_match", {9'h000, ~k[0]}, {9'h000, id_match});
    cmp("boot_device", {9'h000, s == 4'h0}, {9'h000, boot_device});
  endtask
  always @(posedge clock)
  begin
    logic [9:0] n;
    n = 10'h3FF;
    if (gpi_pend || op_refused === 1'b1 || prog_done === 1'b1)
    begin
      if (note_q.size() > 0)
        n = note_q.pop_front();
      if (gpi_pend)
        cmp("gpi_rd_data", n, {5'h18, gpi_rd_data});
      else if (op_refused === 1'b1)
        cmp("op_refused", n, 10'h000);
      else if (n[9:8] == 2'h2)
        cmp("prog_data", n, {2'h2, prog_data});
      else
        cmp("prog_done", n, 10'h100);
    end
    if (mode !== 1'b1)
      cmp("ready_busy_oe", 10'h000, {9'h000, rb_oe});
    else if (busy === 1'b1 && ld_n === 1'b1)
      cmp("ready_busy_level", 10'h000, {9'h000, rb_level});
    cmp("ready_busy_o", 10'h000, {9'h000, rb_o});
    gpi_pend <= gpi_rd;
  end
  always @(posedge clock)
  begin
    cycles++;
    // generous ceiling: the whole sequence needs well under a thousand cycles
    if (cycles == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int k = 0; k < 4; k++)
      id_chk(k);
    for (int k = 0; k < 3; k++)
      gpi_read();
    for (int k = 0; k < 8; k++)
      bus_op(k[2], k[1], k[0]);
    drv_req <= 1'b1;
    drv_data <= 4'h5;
    repeat (2) @(posedge clock);
    cmp("lad_out", 10'h015, {5'h00, lad_oe, lad_out});
    init_n <= 1'b0;
    #1;
    cmp("lad_oe in reset", 10'h000, {9'h000, lad_oe});
    cmp("device_reset_n", 10'h000, {9'h000, dev_rst_n});
    @(posedge clock);
    init_n <= 1'b1;
    drv_req <= 1'b0;
    sv <= 1'b1;
    repeat (4) @(posedge clock);
    cmp("mode", 10'h001, {9'h000, mode});
    tbl_n <= 1'b0;
    wp_pin <= 1'b0;
    boot_lk <= 1'b0;
    blk_lk <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      nxt();
      aai_load(rng[7:0], 1'b0);
    end
    aai_load(8'hC3, 1'b1);
    for (int k = 0; k < 4; k++)
      id_chk(k);
    for (int k = 0; k < 3; k++)
      gpi_read();
    sv <= 1'b0;
    repeat (4) @(posedge clock);
    cmp("mode", 10'h000, {9'h000, mode});
    cmp("pending notes", 10'h000, 10'(note_q.size()));
    end_sim();
  end
endmodule
`default_nettype wire
